/* hw/evpal_loader.sv */
// Autoloader that copies EEPROM words 21 to 39 into switch registers.
//
// Functional notes
// - Word 21 to port 1 61H/66H.
// - Word 22 to port 1 67H/6DH.
// - Word 23 to port 2 61H/66H.
// - Word 24 to port 2 67H/6DH.
// - Word 25 to port 3 61H/66H.
// - Word 26 to port 3 67H/6DH.
// - Port control loads only when [3:2]=01.
// - Word 27 to port 0 6EH/6FH.
// - Word 28 to port 1 6EH/6FH.
// - Word 29 to port 2 6EH/6FH.
// - Word 30 to port 3 6EH/6FH.
// - Word 31 to D0H/D1H when [7:6]=01.
// - Words 32-35 to B0H-B7H when [9:8]=01.
// - Words 36-39 to B8H upward, same condition.
// - Word 39 high byte to BFH.
// - Field [3:2]=01 accepts port control words.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module evpal_loader (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ee_req,
  output logic [5:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [15:0] ee_rdata,
  output logic rf_we,
  output evpal_pkg::evpal_rfwr_s rf_wr,
  output logic load_done
);
  import evpal_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_START,
    S_CTRL_REQ,
    S_MAP,
    S_CHECK,
    S_DATA_REQ,
    S_WR_LO,
    S_WR_HI,
    S_NEXT,
    S_DONE
  } evpal_state_e;

  evpal_state_e state_q;
  evpal_state_e state_d;
  logic [5:0] word_q;
  logic [5:0] word_d;
  logic [15:0] ctrl_q;
  logic [15:0] data_q;
  logic [7:0] count_q;
  logic ee_req_q;
  logic rf_we_q;
  evpal_rfwr_s rf_wr_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic reload_q;
  evpal_map_s map;
  logic accept;
  logic acc_pctl;
  logic acc_vtag;
  logic acc_prio;
  logic acc_vgrp;
  logic answer;
  logic access;
  logic mapped;
  logic [31:0] rdata_d;

  // ------------------------------------------------------------------
  // Word map lookup
  // ------------------------------------------------------------------
  evpal_word_map u_map (
    .pclk(pclk),
    .presetn(presetn),
    .word_idx(word_q),
    .map_q(map)
  );

  // ------------------------------------------------------------------
  // Group acceptance from the control word
  // ------------------------------------------------------------------
  assign acc_pctl =
    (ctrl_q[EVPAL_ACC_PCTL_LSB +: 2] == EVPAL_ACC_YES);
  assign acc_vtag =
    (ctrl_q[EVPAL_ACC_VTAG_LSB +: 2] == EVPAL_ACC_YES);
  assign acc_prio =
    (ctrl_q[EVPAL_ACC_PRIO_LSB +: 2] == EVPAL_ACC_YES);
  assign acc_vgrp =
    (ctrl_q[EVPAL_ACC_VGRP_LSB +: 2] == EVPAL_ACC_YES);

  always_comb begin
    case (map.grp)
      EVPAL_GRP_PCTL: accept = acc_pctl;
      EVPAL_GRP_VTAG: accept = acc_vtag;
      EVPAL_GRP_PRIO: accept = acc_prio;
      EVPAL_GRP_VGRP: accept = acc_vgrp;
      default: accept = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    case (state_q)
      S_START: begin
        word_d = EVPAL_W_CTRL;
        state_d = S_CTRL_REQ;
      end
      S_CTRL_REQ: begin
        if (ee_req_q && ee_ack) begin
          word_d = EVPAL_W_FIRST;
          state_d = S_MAP;
        end
      end
      S_MAP: begin
        state_d = S_CHECK;
      end
      S_CHECK: begin
        if (accept) begin
          state_d = S_DATA_REQ;
        end else begin
          state_d = S_NEXT;
        end
      end
      S_DATA_REQ: begin
        if (ee_req_q && ee_ack) begin
          state_d = S_WR_LO;
        end
      end
      S_WR_LO: begin
        state_d = S_WR_HI;
      end
      S_WR_HI: begin
        state_d = S_NEXT;
      end
      S_NEXT: begin
        if (word_q == EVPAL_W_LAST) begin
          state_d = S_DONE;
        end else begin
          word_d = word_q + 6'h01;
          state_d = S_MAP;
        end
      end
      S_DONE: begin
        if (reload_q) begin
          state_d = S_START;
        end
      end
      default: state_d = S_START;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_START;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= EVPAL_W_CTRL;
    end else begin
      word_q <= word_d;
    end
  end

  // ------------------------------------------------------------------
  // EEPROM read request
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_req_q <= 1'b0;
    end else if (ee_req_q && ee_ack) begin
      ee_req_q <= 1'b0;
    end else if ((state_q == S_CTRL_REQ) || (state_q == S_DATA_REQ)) begin
      ee_req_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Captured control word and data word
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= EVPAL_CTRLWORD_RST;
    end else if (state_q == S_CTRL_REQ && ee_req_q && ee_ack) begin
      ctrl_q <= ee_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 16'h0000;
    end else if (state_q == S_DATA_REQ && ee_req_q && ee_ack) begin
      data_q <= ee_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Register file writes, low byte then high byte
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we_q <= 1'b0;
    end else if (state_q == S_WR_LO || state_q == S_WR_HI) begin
      rf_we_q <= 1'b1;
    end else begin
      rf_we_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_wr_q <= '{EVPAL_PORT0, 8'h00, 8'h00};
    end else if (state_q == S_WR_LO) begin
      rf_wr_q <= '{map.port, map.lo_addr, data_q[7:0]};
    end else if (state_q == S_WR_HI) begin
      rf_wr_q <= '{map.port, map.hi_addr, data_q[15:8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= EVPAL_COUNT_RST;
    end else if (state_q == S_START) begin
      count_q <= EVPAL_COUNT_RST;
    end else if (state_q == S_WR_LO || state_q == S_WR_HI) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Completion flag
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_d == S_DONE);
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign answer = psel && !pready_q && done_q;
  assign access = psel && penable && pready_q;
  assign mapped = (paddr == EVPAL_OFS_STATUS) ||
                  (paddr == EVPAL_OFS_CTRLWORD) ||
                  (paddr == EVPAL_OFS_COMMAND) ||
                  (paddr == EVPAL_OFS_COUNT);

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      EVPAL_OFS_STATUS: begin
        rdata_d[EVPAL_ST_DONE] = done_q;
        rdata_d[EVPAL_ST_BUSY] = !done_q;
        rdata_d[EVPAL_ST_WORD_LSB +: 6] = word_q;
      end
      EVPAL_OFS_CTRLWORD: rdata_d[15:0] = ctrl_q;
      EVPAL_OFS_COUNT: rdata_d[7:0] = count_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Hold pready low while loading so processor access waits for it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (answer) begin
      pready_q <= 1'b1;
    end else begin
      pready_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (answer) begin
      pslverr_q <= !mapped;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (answer) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // A reload only takes effect from the finished state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= 1'b0;
    end else if (access && pwrite && paddr == EVPAL_OFS_COMMAND) begin
      reload_q <= pwdata[EVPAL_CMD_RELOAD];
    end else begin
      reload_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ee_req = ee_req_q;
  assign ee_addr = word_q;
  assign rf_we = rf_we_q;
  assign rf_wr = rf_wr_q;
  assign load_done = done_q;

endmodule

`default_nettype wire

/* hw/evpal_pkg.sv */
// Package with constants and types for the EEPROM port and VLAN autoloader.
package evpal_pkg;

  // ------------------------------------------------------------------
  // EEPROM word indices
  // ------------------------------------------------------------------
  localparam logic [5:0] EVPAL_W_CTRL = 6'h10;
  localparam logic [5:0] EVPAL_W_FIRST = 6'h15;
  localparam logic [5:0] EVPAL_W_LAST = 6'h27;
  localparam logic [5:0] EVPAL_W_GRP_BASE = 6'h20;

  // ------------------------------------------------------------------
  // Accept fields of the control word
  // ------------------------------------------------------------------
  localparam int EVPAL_ACC_PCTL_LSB = 2;
  localparam int EVPAL_ACC_VTAG_LSB = 4;
  localparam int EVPAL_ACC_PRIO_LSB = 6;
  localparam int EVPAL_ACC_VGRP_LSB = 8;
  localparam logic [1:0] EVPAL_ACC_YES = 2'h1;

  // ------------------------------------------------------------------
  // Switch register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] EVPAL_RA_PCTL1_LO = 8'h61;
  localparam logic [7:0] EVPAL_RA_PCTL1_HI = 8'h66;
  localparam logic [7:0] EVPAL_RA_PCTL2_LO = 8'h67;
  localparam logic [7:0] EVPAL_RA_PCTL2_HI = 8'h6D;
  localparam logic [7:0] EVPAL_RA_VTAG_LO = 8'h6E;
  localparam logic [7:0] EVPAL_RA_VTAG_HI = 8'h6F;
  localparam logic [7:0] EVPAL_RA_PRIO_LO = 8'hD0;
  localparam logic [7:0] EVPAL_RA_PRIO_HI = 8'hD1;
  localparam logic [7:0] EVPAL_RA_VGRP_BASE = 8'hB0;

  // ------------------------------------------------------------------
  // Port numbers
  // ------------------------------------------------------------------
  localparam logic [1:0] EVPAL_PORT0 = 2'h0;
  localparam logic [1:0] EVPAL_PORT1 = 2'h1;
  localparam logic [1:0] EVPAL_PORT2 = 2'h2;
  localparam logic [1:0] EVPAL_PORT3 = 2'h3;

  // ------------------------------------------------------------------
  // APB register offsets and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] EVPAL_OFS_STATUS = 8'h00;
  localparam logic [7:0] EVPAL_OFS_CTRLWORD = 8'h04;
  localparam logic [7:0] EVPAL_OFS_COMMAND = 8'h08;
  localparam logic [7:0] EVPAL_OFS_COUNT = 8'h0C;
  localparam int EVPAL_ST_DONE = 0;
  localparam int EVPAL_ST_BUSY = 1;
  localparam int EVPAL_ST_WORD_LSB = 8;
  localparam int EVPAL_CMD_RELOAD = 0;
  localparam logic [15:0] EVPAL_CTRLWORD_RST = 16'h0000;
  localparam logic [7:0] EVPAL_COUNT_RST = 8'h00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    EVPAL_GRP_NONE,
    EVPAL_GRP_PCTL,
    EVPAL_GRP_VTAG,
    EVPAL_GRP_PRIO,
    EVPAL_GRP_VGRP
  } evpal_grp_e;

  typedef struct packed {
    logic [1:0] port;
    logic [7:0] addr;
    logic [7:0] data;
  } evpal_rfwr_s;

  typedef struct packed {
    evpal_grp_e grp;
    logic [1:0] port;
    logic [7:0] lo_addr;
    logic [7:0] hi_addr;
  } evpal_map_s;

endpackage

/* hw/evpal_word_map.sv */
// Lookup from an EEPROM word index to its group and target registers.
`timescale 1ns/100ps
`default_nettype none

module evpal_word_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] word_idx,
  output evpal_pkg::evpal_map_s map_q
);
  import evpal_pkg::*;

  evpal_map_s map_d;
  logic [2:0] grp_ofs;

  always_comb begin
    grp_ofs = 3'(word_idx - EVPAL_W_GRP_BASE);
    map_d = '{EVPAL_GRP_NONE, EVPAL_PORT0, 8'h00, 8'h00};
    case (word_idx)
      6'h15: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT1, EVPAL_RA_PCTL1_LO,
                       EVPAL_RA_PCTL1_HI};
      6'h16: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT1, EVPAL_RA_PCTL2_LO,
                       EVPAL_RA_PCTL2_HI};
      6'h17: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT2, EVPAL_RA_PCTL1_LO,
                       EVPAL_RA_PCTL1_HI};
      6'h18: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT2, EVPAL_RA_PCTL2_LO,
                       EVPAL_RA_PCTL2_HI};
      6'h19: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT3, EVPAL_RA_PCTL1_LO,
                       EVPAL_RA_PCTL1_HI};
      6'h1A: map_d = '{EVPAL_GRP_PCTL, EVPAL_PORT3, EVPAL_RA_PCTL2_LO,
                       EVPAL_RA_PCTL2_HI};
      6'h1B: map_d = '{EVPAL_GRP_VTAG, EVPAL_PORT0, EVPAL_RA_VTAG_LO,
                       EVPAL_RA_VTAG_HI};
      6'h1C: map_d = '{EVPAL_GRP_VTAG, EVPAL_PORT1, EVPAL_RA_VTAG_LO,
                       EVPAL_RA_VTAG_HI};
      6'h1D: map_d = '{EVPAL_GRP_VTAG, EVPAL_PORT2, EVPAL_RA_VTAG_LO,
                       EVPAL_RA_VTAG_HI};
      6'h1E: map_d = '{EVPAL_GRP_VTAG, EVPAL_PORT3, EVPAL_RA_VTAG_LO,
                       EVPAL_RA_VTAG_HI};
      6'h1F: map_d = '{EVPAL_GRP_PRIO, EVPAL_PORT0, EVPAL_RA_PRIO_LO,
                       EVPAL_RA_PRIO_HI};
      6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27: begin
        map_d.grp = EVPAL_GRP_VGRP;
        map_d.port = EVPAL_PORT0;
        map_d.lo_addr = EVPAL_RA_VGRP_BASE +
          {4'h0, grp_ofs, 1'b0};
        map_d.hi_addr = EVPAL_RA_VGRP_BASE +
          {4'h0, grp_ofs, 1'b1};
      end
      default: map_d = '{EVPAL_GRP_NONE, EVPAL_PORT0, 8'h00, 8'h00};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_q <= '{EVPAL_GRP_NONE, EVPAL_PORT0, 8'h00, 8'h00};
    end else begin
      map_q <= map_d;
    end
  end

endmodule

`default_nettype wire

/* dv/evpal_loader_assertions.sv */
// Checker for the ports of the EEPROM autoloader.
`timescale 1ns/100ps
`default_nettype none

module evpal_loader_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ee_req,
  input wire logic [5:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [15:0] ee_rdata,
  input wire logic rf_we,
  input wire evpal_pkg::evpal_rfwr_s rf_wr,
  input wire logic load_done
);
  import evpal_pkg::*;
  logic [15:0] ctrl_q;
  logic [5:0] last_q;
  logic [1:0] fld;
  logic take;
  assign take = ee_req && ee_ack;
  // --------------------------------------------------------------
  // Helper state: captured control word and last word taken.
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 16'h0000;
      last_q <= 6'h00;
    end else if (take) begin
      last_q <= ee_addr;
      if (ee_addr == 6'h10) begin
        ctrl_q <= ee_rdata;
      end
    end
  end
  always_comb begin
    if (ee_addr <= 6'h1A) begin
      fld = ctrl_q[3:2];
    end else if (ee_addr <= 6'h1E) begin
      fld = ctrl_q[5:4];
    end else if (ee_addr == 6'h1F) begin
      fld = ctrl_q[7:6];
    end else begin
      fld = ctrl_q[9:8];
    end
  end
  // --------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_REQ_STANDS: assert property (
    ee_req && !ee_ack |=> ee_req && $stable(ee_addr))
    else $error("request dropped before ack");
  AST_ACK_DROP: assert property (
    take |=> !ee_req)
    else $error("request held after ack");
  AST_LO_BYTE: assert property (
    take && ee_addr != 6'h10 |-> ##2 rf_we &&
    rf_wr.data == $past(ee_rdata[7:0], 2))
    else $error("low byte write wrong");
  AST_HI_BYTE: assert property (
    take && ee_addr != 6'h10 |-> ##3 rf_we &&
    rf_wr.data == $past(ee_rdata[15:8], 3))
    else $error("high byte write wrong");
  AST_CTRL_SILENT: assert property (
    take && ee_addr == 6'h10 |=> !rf_we [*2])
    else $error("control word written out");
  AST_GATED: assert property (
    $rose(ee_req) && ee_addr != 6'h10 |-> fld == 2'h1)
    else $error("word of refused group requested");
  AST_RANGE: assert property (
    ee_req |-> ee_addr == 6'h10 || (ee_addr >= 6'h15 && ee_addr <= 6'h27))
    else $error("word index out of range");
  AST_ASCEND: assert property (
    $rose(ee_req) && ee_addr != 6'h10 |-> ee_addr > last_q)
    else $error("words not ascending");
  AST_APB_HELD: assert property (
    pready |-> load_done)
    else $error("bus answered while loading");
  AST_DONE_QUIET: assert property (
    load_done |-> !ee_req && !rf_we)
    else $error("activity after load done");
  AST_ERR_READY: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  cover property (take && ee_addr == 6'h27);
  cover property ($rose(load_done));
  cover property (pslverr);
endmodule

`default_nettype wire

/* dv/evpal_ee_model.sv */
// Behavioural model of the configuration EEPROM word port.
`timescale 1ns/100ps
`default_nettype none

module evpal_ee_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ee_req,
  input wire logic [5:0] ee_addr,
  input wire logic [1:0] lat,
  output logic ee_ack,
  output logic [15:0] ee_rdata
);
  logic [15:0] mem [0:63];
  logic [1:0] cnt_q;
  // --------------------------------------------------------------
  // Answers after lat idle cycles; data toggles outside the ack.
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      ee_ack <= 1'b0;
      ee_rdata <= 16'hA5A5;
    end else begin
      ee_ack <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee_req && !ee_ack) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == lat) begin
          cnt_q <= 2'h0;
          ee_ack <= 1'b1;
          ee_rdata <= mem[ee_addr];
        end
      end
    end
  end
endmodule

`default_nettype wire

/* dv/evpal_loader_tb.sv */
// Self-checking bench for the EEPROM autoloader.
`timescale 1ns/100ps
`default_nettype none

module evpal_loader_tb;
  import evpal_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic ee_req, ee_ack, rf_we, load_done, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] ee_addr;
  logic [15:0] ee_rdata, c;
  logic [1:0] lat;
  evpal_rfwr_s rf_wr;
  evpal_rfwr_s got[$];
  evpal_rfwr_s exp_q[$];
  logic [15:0] tbl [0:4] = '{16'h0000, 16'h03FF, 16'h0104, 16'h0050,
    16'hFEAB};
  int fail_count = 0;
  int checked = 0;
  int seed = 32'h6EC2;
  int n;
  evpal_loader uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ee_req, .ee_addr, .ee_ack,
    .ee_rdata, .rf_we, .rf_wr, .load_done);
  evpal_ee_model eem (.pclk, .presetn, .ee_req, .ee_addr, .lat, .ee_ack,
    .ee_rdata);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (rf_we === 1'b1) got.push_back(rf_wr);
  // --------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fill(logic [15:0] cw);
    for (int i = 0; i < 64; i++) begin
      rd = $random(seed);
      eem.mem[i] = rd[15:0];
    end
    eem.mem[16] = cw;
    lat <= rd[17:16];
  endtask
  function automatic void build(logic [15:0] cw);
    logic [1:0] f, p;
    logic [7:0] lo, hi;
    logic [15:0] d;
    exp_q.delete();
    for (int w = 21; w <= 39; w++) begin
      d = eem.mem[w];
      p = 2'h0;
      lo = 8'(8'hB0 + 2 * (w - 32));
      hi = lo + 8'h01;
      f = cw[9:8];
      if (w <= 26) begin
        f = cw[3:2];
        p = 2'((w - 19) / 2);
        lo = (w % 2) ? 8'h61 : 8'h67;
        hi = (w % 2) ? 8'h66 : 8'h6D;
      end else if (w <= 30) begin
        f = cw[5:4];
        p = 2'(w - 27);
        lo = 8'h6E;
        hi = 8'h6F;
      end else if (w == 31) begin
        f = cw[7:6];
        lo = 8'hD0;
        hi = 8'hD1;
      end
      if (f == 2'h1) begin
        exp_q.push_back({p, lo, d[7:0]});
        exp_q.push_back({p, hi, d[15:8]});
      end
    end
  endfunction
  task automatic finish_load(logic [15:0] cw);
    build(cw);
    apb(1'b0, 8'h00, 32'h0);
    check("status", rd[1:0], 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check("count", rd, 32'(exp_q.size()));
    apb(1'b0, 8'h04, 32'h0);
    check("ctrlword", rd, {16'h0000, cw});
    check("writes", 32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) check("write", 32'(got[i]), 32'(exp_q[i]));
    got.delete();
    $display("load with control %h finished", cw);
  endtask
  task automatic reload(logic [15:0] cw);
    fill(cw);
    apb(1'b1, 8'h08, 32'h1);
    n = 0;
    while (load_done !== 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    finish_load(cw);
  endtask
  // --------------------------------------------------------------
  // Main sequence and watchdog.
  // --------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 2'h0;
    fill(16'h0155);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    finish_load(16'h0155);
    foreach (tbl[i]) reload(tbl[i]);
    for (int k = 0; k < 4; k++) begin
      rd = $random(seed);
      c = rd[15:0];
      reload(c);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("bus error test finished");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule

bind evpal_loader evpal_loader_assertions u_ast (.pclk, .presetn, .pready,
  .pslverr, .ee_req, .ee_addr, .ee_ack, .ee_rdata, .rf_we, .rf_wr,
  .load_done);

`default_nettype wire
